// File: design/cgw_ctrl.sv
// Clock gear, prescaler, clock output, power mode and warm-up control unit.
// Assumes oscillator edges arrive as one-cycle ticks synchronous to clk_i.
// Operation
// [RL1] Five control registers decoded at 0x00 to 0x10, word spaced
// [RL2] Normal mode plus three low-power modes entered by transitions
// [RL3] Clock output picks low-speed, half system, system or timer base
// [RL4] Peripheral clock from geared clock, or undivided high-speed clock
// [RL5] Prescaler divides peripheral clock by 1 to 32; 110, 111 reserved
// [RL6] Gear gives high-speed clock divided by 1, 2, 4 or 8
// [RL7] Warm-up code 000 none; 001 to 111 give 2^10 to 2^16 periods
// [RL8] Warm-up source bit: 0 high-speed, 1 low-speed oscillator
// [RL9] Warm-up timer counts ticks of the selected oscillator
// [RL10] PLL run bit stops the PLL at 0, runs it at 1
// [RL11] PLL stopped after reset; software sets run bit first
// [RL12] Busy status bit reads 1 during warm-up, 0 when done
// [RL13] Busy status readable by software at any time
// [RL14] Writing 1 to start bit starts warm-up; writing 0 does nothing
// [RL15] Start loads count, sets busy; expiry clears it; 000 at once
// [RL16] Reserved bits read zero and ignore writes
// [RL17] PLL use bit selects PLL clock at 1, oscillator at 0; resets 0
// [RL18] Low-power code 001 stop, 010 sleep, 011 idle; others reserved
// [RL19] System clock bit: 0 high-speed, 1 low-speed; oscillators enabled
`timescale 1ns/1ps
module cgw_ctrl
    import cgw_pkg::*;
#(
    parameter int WUP_EXP1 = CGW_WUP_EXP1
)(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       psel_i,
    input  wire logic       penable_i,
    input  wire logic       pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]     prdata_o,
    output logic            pready_o,
    output logic            pslverr_o,
    input  wire logic       high_osc_tick_i,
    input  wire logic       low_osc_tick_i,
    input  wire logic       sleep_req_i,
    input  wire logic       wake_i,
    output cgw_clk_cfg_type clk_cfg_o,
    output logic            gear_tick_o,
    output logic            periph_tick_o,
    output logic            presc_tick_o,
    output logic            clock_output_pin_o,
    output cgw_pm_type      power_mode_o,
    output logic            stop_pins_active_o,
    output logic            warmup_busy_o,
    output logic            irq_o
);
    logic [31:0]          sys_ff;
    logic [31:0]          osc_ff;
    logic [31:0]          low_power_select_ff;
    logic [31:0]          pll_ff;
    logic [31:0]          cksel_ff;
    logic [CGW_IRQ_W-1:0] stat_ff;
    logic [CGW_IRQ_W-1:0] irq_en_ff;
    logic [31:0]          rdata_ff;
    logic [CGW_WUP_W-1:0] wup_cnt_ff;
    logic                 busy_ff;
    logic                 pin_ff;
    cgw_pm_type           pm_ff;
    cgw_pm_type           nxt_pm;
    logic                 acc;
    logic                 setup;
    logic                 hit;
    logic                 wr;
    logic [31:0]          rd_mux;
    logic [2:0]           gear_code;
    logic [2:0]           gear_shift;
    logic [2:0]           prescaler_ratio_code;
    logic [2:0]           prescaler_ratio_shift;
    logic [2:0]           warmup_time;
    logic                 periph_src;
    logic                 sys_tick;
    logic                 half_sys_tick;
    logic                 wup_tick;
    logic                 start;
    logic                 wup_done;
    logic                 wake_ev;
    logic                 out_tick;
    logic [1:0]           cosel;
    logic [CGW_IRQ_W-1:0] irq_set;

    // APB phases and address decode
    assign setup = psel_i && !penable_i;
    assign acc   = psel_i && penable_i;
    always_comb begin
        if (paddr_i == CGW_OFS_SYS) begin          // RL1
            hit = 1'b1;
        end else if (paddr_i == CGW_OFS_OSC) begin
            hit = 1'b1;
        end else if (paddr_i == CGW_OFS_LOW_POWER_SELECT) begin
            hit = 1'b1;
        end else if (paddr_i == CGW_OFS_PLL) begin
            hit = 1'b1;
        end else if (paddr_i == CGW_OFS_CKSEL) begin
            hit = 1'b1;
        end else if (paddr_i == CGW_OFS_IRQ_STAT) begin
            hit = 1'b1;
        end else if (paddr_i == CGW_OFS_IRQ_EN) begin
            hit = 1'b1;
        end else if (paddr_i == CGW_OFS_IRQ_CLR) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end
    assign wr        = acc && pwrite_i && hit;
    assign pready_o  = 1'b1;                        // Zero wait states
    assign pslverr_o = acc && !hit;

    // Read mux; reserved and write-only bits read zero
    always_comb begin
        if (paddr_i == CGW_OFS_SYS) begin
            rd_mux = sys_ff;                        // RL16
        end else if (paddr_i == CGW_OFS_OSC) begin
            rd_mux = osc_ff;                        // RL13
            rd_mux[CGW_BUSY_BIT] = busy_ff;         // RL12
        end else if (paddr_i == CGW_OFS_LOW_POWER_SELECT) begin
            rd_mux = low_power_select_ff;
        end else if (paddr_i == CGW_OFS_PLL) begin
            rd_mux = pll_ff;
        end else if (paddr_i == CGW_OFS_CKSEL) begin
            rd_mux = cksel_ff;
        end else if (paddr_i == CGW_OFS_IRQ_STAT) begin
            rd_mux = {{(32-CGW_IRQ_W){1'b0}}, stat_ff};
        end else if (paddr_i == CGW_OFS_IRQ_EN) begin
            rd_mux = {{(32-CGW_IRQ_W){1'b0}}, irq_en_ff};
        end else begin
            rd_mux = '0;
        end
    end

    // Read data captured in the setup phase, valid in the access phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_ff <= '0;
        end else if (setup) begin
            rdata_ff <= rd_mux;
        end
    end
    assign prdata_o = rdata_ff;

    // System control register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sys_ff <= CGW_SYS_RST;
        end else if (wr && paddr_i == CGW_OFS_SYS) begin
            sys_ff <= pwdata_i & CGW_SYS_MASK;      // RL16
        end
    end

    // Oscillation control; stop exit restores oscillators from standby bits
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_ff <= CGW_OSC_RST;                  // RL11
        end else if (wr && paddr_i == CGW_OFS_OSC) begin
            osc_ff <= pwdata_i & CGW_OSC_MASK;      // RL16
        end else if (pm_ff == CGW_PM_STOP && nxt_pm == CGW_PM_NORMAL) begin
            osc_ff[CGW_XEN_BIT]  <= low_power_select_ff[CGW_RXEN_BIT];
            osc_ff[CGW_XTEN_BIT] <= low_power_select_ff[CGW_RXTEN_BIT];
        end
    end

    // Standby, PLL use and system clock select registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_power_select_ff  <= CGW_LOW_POWER_SELECT_RST;
            pll_ff   <= CGW_PLL_RST;                // RL17
            cksel_ff <= CGW_CKSEL_RST;
        end else if (wr) begin
            if (paddr_i == CGW_OFS_LOW_POWER_SELECT) begin
                low_power_select_ff <= pwdata_i & CGW_LOW_POWER_SELECT_MASK;
            end
            if (paddr_i == CGW_OFS_PLL) begin
                pll_ff <= pwdata_i & CGW_PLL_MASK;
            end
            if (paddr_i == CGW_OFS_CKSEL) begin
                cksel_ff <= pwdata_i & CGW_CKSEL_MASK; // RL19
            end
        end
    end

    // Gear code to divider shift; reserved codes stay undivided
    assign gear_code = sys_ff[CGW_GEAR_LSB +: 3];
    always_comb begin
        case (gear_code)                            // RL6
            CGW_GEAR_DIV2: gear_shift = 3'h1;
            CGW_GEAR_DIV4: gear_shift = 3'h2;
            CGW_GEAR_DIV8: gear_shift = 3'h3;
            default:       gear_shift = 3'h0;
        endcase
    end

    // Prescaler code is the shift itself; reserved codes give /1
    assign prescaler_ratio_code  = sys_ff[CGW_PRESCALER_RATIO_LSB +: 3];
    assign prescaler_ratio_shift = (prescaler_ratio_code > CGW_PRESCALER_RATIO_MAX) ? 3'h0 : prescaler_ratio_code; // RL5
    assign periph_src = sys_ff[CGW_PERIPH_SOURCE_SELECT_BIT];

    // Geared clock from the high-speed oscillator
    cgw_tick_div u_gear_div (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .tick_i  (high_osc_tick_i),
        .shift_i (gear_shift),
        .tick_o  (gear_tick_o)
    );

    // Peripheral clock source select
    assign periph_tick_o = periph_src ? high_osc_tick_i : gear_tick_o; // RL4

    // Prescaler clock, also the timer base clock
    cgw_tick_div u_presc_div (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .tick_i  (periph_tick_o),
        .shift_i (prescaler_ratio_shift),
        .tick_o  (presc_tick_o)
    );

    // System clock and its half rate
    assign sys_tick = cksel_ff[CGW_SYSCLK_SOURCE_BIT] ? low_osc_tick_i
                                              : gear_tick_o; // RL19
    cgw_tick_div u_half_div (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .tick_i  (sys_tick),
        .shift_i (CGW_SHIFT_1),
        .tick_o  (half_sys_tick)
    );

    // Clock output pin toggles on each tick of the selected clock
    assign cosel = sys_ff[CGW_COSEL_LSB +: 2];
    always_comb begin
        case (cosel)                                // RL3
            CGW_CO_LOW:  out_tick = low_osc_tick_i;
            CGW_CO_HALF: out_tick = half_sys_tick;
            CGW_CO_SYS:  out_tick = sys_tick;
            default:     out_tick = presc_tick_o;
        endcase
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_ff <= 1'b0;
        end else if (out_tick) begin
            pin_ff <= !pin_ff;                      // RL3
        end
    end
    assign clock_output_pin_o = pin_ff;

    // Warm-up timer
    assign warmup_time     = osc_ff[CGW_WARMUP_TIME_LSB +: 3];
    assign start    = wr && paddr_i == CGW_OFS_OSC
                      && pwdata_i[CGW_START_BIT];   // RL14
    assign wup_tick = osc_ff[CGW_WSEL_BIT] ? low_osc_tick_i
                                           : high_osc_tick_i; // RL8
    assign wup_done = (busy_ff && !start && wup_tick
                       && wup_cnt_ff == CGW_WUP_W'(1))
                      || (start && pwdata_i[CGW_WARMUP_TIME_LSB +: 3]
                          == CGW_WARMUP_TIME_NONE);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_ff    <= 1'b0;
            wup_cnt_ff <= '0;
        end else if (start) begin
            // Count taken from the value written in the same access
            busy_ff    <= pwdata_i[CGW_WARMUP_TIME_LSB +: 3] != CGW_WARMUP_TIME_NONE; // RL7
            wup_cnt_ff <= CGW_WUP_W'(1) << (WUP_EXP1 - 1
                          + int'(pwdata_i[CGW_WARMUP_TIME_LSB +: 3])); // RL15
        end else if (busy_ff && wup_tick) begin
            wup_cnt_ff <= wup_cnt_ff - CGW_WUP_W'(1);  // RL9
            if (wup_cnt_ff == CGW_WUP_W'(1)) begin
                busy_ff <= 1'b0;                    // RL15
            end
        end
    end
    assign warmup_busy_o = busy_ff;

    // Power mode transitions
    always_comb begin
        nxt_pm = pm_ff;
        case (pm_ff)
            CGW_PM_NORMAL: begin
                if (sleep_req_i) begin
                    case (low_power_select_ff[CGW_LOW_POWER_SELECT_LSB +: 3]) // RL18
                        CGW_LP_STOP:  nxt_pm = CGW_PM_STOP;
                        CGW_LP_SLEEP: nxt_pm = CGW_PM_SLEEP;
                        CGW_LP_IDLE:  nxt_pm = CGW_PM_IDLE;
                        default:      nxt_pm = CGW_PM_NORMAL;
                    endcase
                end
            end
            default: begin
                if (wake_i) begin
                    nxt_pm = CGW_PM_NORMAL;         // RL2
                end
            end
        endcase
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pm_ff <= CGW_PM_NORMAL;
        end else begin
            pm_ff <= nxt_pm;                        // RL2
        end
    end
    assign power_mode_o       = pm_ff;
    assign wake_ev            = pm_ff != CGW_PM_NORMAL && wake_i;
    assign stop_pins_active_o = pm_ff == CGW_PM_STOP
                                && low_power_select_ff[CGW_DRVE_BIT];

    // Clock-tree controls; stop mode halts oscillators and PLL
    always_comb begin
        clk_cfg_o.high_osc_en   = osc_ff[CGW_XEN_BIT] && pm_ff != CGW_PM_STOP;
        clk_cfg_o.low_osc_en    = osc_ff[CGW_XTEN_BIT] && pm_ff != CGW_PM_STOP;
        clk_cfg_o.pll_run       = osc_ff[CGW_PLL_RUN_BIT]
                                  && pm_ff != CGW_PM_STOP; // RL10
        clk_cfg_o.pll_use       = pll_ff[CGW_PLL_USE_BIT]; // RL17
        clk_cfg_o.sysclk_source = cksel_ff[CGW_SYSCLK_SOURCE_BIT];
    end

    // Interrupt status; a new event wins over a same-cycle clear
    assign irq_set = {wake_ev, wup_done};
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stat_ff   <= '0;
            irq_en_ff <= '0;
        end else begin
            if (wr && paddr_i == CGW_OFS_IRQ_CLR) begin
                stat_ff <= (stat_ff & ~pwdata_i[CGW_IRQ_W-1:0]) | irq_set;
            end else begin
                stat_ff <= stat_ff | irq_set;
            end
            if (wr && paddr_i == CGW_OFS_IRQ_EN) begin
                irq_en_ff <= pwdata_i[CGW_IRQ_W-1:0];
            end
        end
    end
    assign irq_o = |(stat_ff & irq_en_ff);

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_idle_req;
        pm_ff == CGW_PM_NORMAL && sleep_req_i
            && low_power_select_ff[CGW_LOW_POWER_SELECT_LSB +: 3] == CGW_LP_IDLE;
    endsequence
    sequence s_timed_start;
        start && pwdata_i[CGW_WARMUP_TIME_LSB +: 3] != CGW_WARMUP_TIME_NONE;
    endsequence

    unmapped_err_a: assert property ( // RL1
        acc && paddr_i == 12'h020 |-> pslverr_o && pready_o)
        else $error("unmapped access not flagged");
    sys_reserved_a: assert property ( // RL16
        acc && !pwrite_i && paddr_i == CGW_OFS_SYS
        |-> (prdata_o & ~CGW_SYS_MASK) == 32'h0)
        else $error("reserved system bits read nonzero");
    idle_entry_a: assert property ( // RL18
        s_idle_req ##1 1'b1 |-> power_mode_o == CGW_PM_IDLE)
        else $error("idle mode not entered");
    stop_osc_a: assert property ( // RL2
        power_mode_o == CGW_PM_STOP
        |-> !clk_cfg_o.high_osc_en && !clk_cfg_o.pll_run)
        else $error("oscillator runs in stop mode");
    busy_set_a: assert property ( // RL15
        s_timed_start |=> warmup_busy_o [*2])
        else $error("warm-up busy not held after start");
    no_wup_a: assert property ( // RL7
        start && pwdata_i[CGW_WARMUP_TIME_LSB +: 3] == CGW_WARMUP_TIME_NONE
        |=> !warmup_busy_o && stat_ff[CGW_IRQ_WUP])
        else $error("code zero warm-up not immediate");
    busy_hold_a: assert property ( // RL9
        warmup_busy_o && !wup_tick && !start |=> warmup_busy_o)
        else $error("warm-up ended without source tick");
    start_zero_a: assert property ( // RL14
        wr && paddr_i == CGW_OFS_OSC && !pwdata_i[CGW_START_BIT]
        && !warmup_busy_o |=> !warmup_busy_o)
        else $error("writing zero started warm-up");
    busy_read_a: assert property ( // RL12
        acc && !pwrite_i && paddr_i == CGW_OFS_OSC
        |-> prdata_o[CGW_BUSY_BIT] == $past(warmup_busy_o))
        else $error("busy readback wrong");
    pll_run_a: assert property ( // RL11
        clk_cfg_o.pll_run |-> osc_ff[CGW_PLL_RUN_BIT])
        else $error("PLL runs without its run bit");
    periph_src_a: assert property ( // RL4
        periph_src |-> periph_tick_o == high_osc_tick_i)
        else $error("peripheral clock source wrong");
    gear_one_a: assert property ( // RL6
        gear_code == CGW_GEAR_DIV1 && high_osc_tick_i |-> gear_tick_o)
        else $error("undivided gear missed a tick");
    presc_one_a: assert property ( // RL5
        prescaler_ratio_code == 3'h0 && periph_tick_o |-> presc_tick_o)
        else $error("prescaler by one missed a tick");
    clkout_sys_a: assert property ( // RL3
        cosel == CGW_CO_SYS && sys_tick
        |=> clock_output_pin_o != $past(clock_output_pin_o))
        else $error("clock output did not follow system clock");

endmodule : cgw_ctrl

// File: design/cgw_pkg.sv
// Constants, register layout and types of the clock gear and warm-up unit.
// Assumes a single 250 MHz system clock and a 32-bit APB register port.
package cgw_pkg;

    // Register byte offsets from the unit base
    localparam logic [11:0] CGW_OFS_SYS      = 12'h000;
    localparam logic [11:0] CGW_OFS_OSC      = 12'h004;
    localparam logic [11:0] CGW_OFS_LOW_POWER_SELECT     = 12'h008;
    localparam logic [11:0] CGW_OFS_PLL      = 12'h00c;
    localparam logic [11:0] CGW_OFS_CKSEL    = 12'h010;
    localparam logic [11:0] CGW_OFS_IRQ_STAT = 12'h014;
    localparam logic [11:0] CGW_OFS_IRQ_EN   = 12'h018;
    localparam logic [11:0] CGW_OFS_IRQ_CLR  = 12'h01c;

    // Writable bit masks; all other bits except the busy status bit read as zero
    localparam logic [31:0] CGW_SYS_MASK   = 32'h0003_1707;
    localparam logic [31:0] CGW_OSC_MASK   = 32'h0000_337c;
    localparam logic [31:0] CGW_LOW_POWER_SELECT_MASK  = 32'h0003_0307;
    localparam logic [31:0] CGW_PLL_MASK   = 32'h0000_0001;
    localparam logic [31:0] CGW_CKSEL_MASK = 32'h0000_0002;

    // Reset values
    localparam logic [31:0] CGW_SYS_RST   = 32'h0001_0000;
    localparam logic [31:0] CGW_OSC_RST   = 32'h0000_0310;
    localparam logic [31:0] CGW_LOW_POWER_SELECT_RST  = 32'h0000_0103;
    localparam logic [31:0] CGW_PLL_RST   = 32'h0000_0000;
    localparam logic [31:0] CGW_CKSEL_RST = 32'h0000_0000;

    // System control fields
    localparam int CGW_GEAR_LSB  = 0;
    localparam int CGW_PRESCALER_RATIO_LSB  = 8;
    localparam int CGW_PERIPH_SOURCE_SELECT_BIT = 12;
    localparam int CGW_COSEL_LSB = 16;
    // Oscillation control fields
    localparam int CGW_START_BIT = 0;
    localparam int CGW_BUSY_BIT  = 1;
    localparam int CGW_PLL_RUN_BIT = 2;
    localparam int CGW_WSEL_BIT  = 3;
    localparam int CGW_WARMUP_TIME_LSB  = 4;
    localparam int CGW_XEN_BIT   = 8;
    localparam int CGW_XTEN_BIT  = 9;
    // Standby control fields
    localparam int CGW_LOW_POWER_SELECT_LSB  = 0;
    localparam int CGW_RXEN_BIT  = 8;
    localparam int CGW_RXTEN_BIT = 9;
    localparam int CGW_DRVE_BIT  = 16;
    // Single-bit selections
    localparam int CGW_PLL_USE_BIT = 0;
    localparam int CGW_SYSCLK_SOURCE_BIT  = 1;

    // Field codes
    localparam logic [2:0] CGW_GEAR_DIV1 = 3'h0;
    localparam logic [2:0] CGW_GEAR_DIV2 = 3'h4;
    localparam logic [2:0] CGW_GEAR_DIV4 = 3'h5;
    localparam logic [2:0] CGW_GEAR_DIV8 = 3'h6;
    localparam logic [2:0] CGW_PRESCALER_RATIO_MAX  = 3'h5;
    localparam logic [2:0] CGW_WARMUP_TIME_NONE = 3'h0;
    localparam logic [2:0] CGW_LP_STOP   = 3'h1;
    localparam logic [2:0] CGW_LP_SLEEP  = 3'h2;
    localparam logic [2:0] CGW_LP_IDLE   = 3'h3;
    localparam logic [1:0] CGW_CO_LOW    = 2'h0;
    localparam logic [1:0] CGW_CO_HALF   = 2'h1;
    localparam logic [1:0] CGW_CO_SYS    = 2'h2;
    localparam logic [1:0] CGW_CO_TBASE  = 2'h3;
    localparam logic [2:0] CGW_SHIFT_1   = 3'h1;

    // Counter widths and warm-up exponent of code 001
    localparam int CGW_DIV_W     = 6;
    localparam int CGW_WUP_W     = 17;
    localparam int CGW_WUP_EXP1  = 10;
    localparam int CGW_IRQ_W     = 2;
    localparam int CGW_IRQ_WUP   = 0;
    localparam int CGW_IRQ_WAKE  = 1;

    // Power states, Gray coded along normal-idle-sleep-stop
    typedef enum logic [1:0] {
        CGW_PM_NORMAL = 2'b00,
        CGW_PM_IDLE   = 2'b01,
        CGW_PM_SLEEP  = 2'b11,
        CGW_PM_STOP   = 2'b10
    } cgw_pm_type;

    // Oscillator and clock-tree controls driven out of the unit
    typedef struct packed {
        logic high_osc_en;
        logic low_osc_en;
        logic pll_run;
        logic pll_use;
        logic sysclk_source;
    } cgw_clk_cfg_type;

endpackage : cgw_pkg

// File: design/cgw_tick_div.sv
// Power-of-two divider of a clock tick stream.
// Assumes tick_i is a one-cycle pulse per source clock edge and shift_i <= 5.
`timescale 1ns/1ps
module cgw_tick_div
    import cgw_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] shift_i,
    output logic            tick_o
);
    logic [CGW_DIV_W-1:0] cnt_ff;
    logic [CGW_DIV_W-1:0] last;

    // Terminal count for the chosen ratio
    assign last = (CGW_DIV_W'(1) << shift_i) - CGW_DIV_W'(1);

    // Count input ticks, wrap at terminal count
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= '0;
        end else if (tick_i) begin
            cnt_ff <= (cnt_ff >= last) ? '0 : cnt_ff + CGW_DIV_W'(1);
        end
    end

    // One output tick per 2^shift input ticks
    assign tick_o = tick_i && (cnt_ff >= last);

endmodule : cgw_tick_div

// File: tb/testbench.sv
// Self-checking bench of the clock gear and warm-up unit.
// Assumes cgw_pkg and cgw_ctrl are compiled before this file.
`timescale 1ns/1ps
module testbench;
    import cgw_pkg::*;
    localparam int EXP1 = 2;
    logic            clk_i = 1'b0;
    logic            nrst_i = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic            hi = 1'b0;
    logic            lo = 1'b0;
    logic            sleep = 1'b0;
    logic            wake = 1'b0;
    logic [11:0]     paddr = '0;
    logic [31:0]     pwdata = '0;
    logic [31:0]     prdata, q;
    logic            pready, pslverr, err, gear, periph, presc, pin;
    logic            stopact, busy, irq, pv;
    cgw_clk_cfg_type cfg;
    cgw_pm_type      pm;
    int              fail_count = 0;
    int              n_tests = 0;
    int              n, g, p, t, f;
    logic [31:0] rv[5] = '{CGW_SYS_RST, CGW_OSC_RST, CGW_LOW_POWER_SELECT_RST,
                           CGW_PLL_RST, CGW_CKSEL_RST};
    logic [31:0] mk[5] = '{CGW_SYS_MASK, CGW_OSC_MASK, CGW_LOW_POWER_SELECT_MASK,
                           CGW_PLL_MASK, CGW_CKSEL_MASK};
    logic [31:0] mv[15] = '{'h0, 'h4, 'h5, 'h6, 'h1006, 'h6, 'h1106,
        'h1206, 'h1306, 'h1406, 'h1506, 'h4, 'h10000, 'h20005, 'h31504};
    int ms[15] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2};
    int me[15] = '{128, 64, 32, 16, 128, 16, 64, 32, 16, 8, 4, 32, 64, 32, 4};
    cgw_pm_type pe[4] = '{CGW_PM_NORMAL, CGW_PM_STOP, CGW_PM_SLEEP, CGW_PM_IDLE};

    // Unit under test with a short warm-up table
    cgw_ctrl #(.WUP_EXP1(EXP1)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .high_osc_tick_i(hi),
        .low_osc_tick_i(lo), .sleep_req_i(sleep), .wake_i(wake),
        .clk_cfg_o(cfg), .gear_tick_o(gear), .periph_tick_o(periph),
        .presc_tick_o(presc), .clock_output_pin_o(pin),
        .power_mode_o(pm), .stop_pins_active_o(stopact),
        .warmup_busy_o(busy), .irq_o(irq));

    // Clock generator
    always #2 clk_i = ~clk_i;

    task automatic check(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        check("read data", q, e);
    endtask : rd

    // Oscillator ticks on consecutive cycles, then idle
    task automatic tk(input logic h, l, input int k);
        repeat (k) begin
            @(posedge clk_i);
            hi <= h;
            lo <= l;
        end
        @(posedge clk_i);
        hi <= 1'b0;
        lo <= 1'b0;
        @(negedge clk_i);
    endtask : tk

    // Mode request or wake pulse of one cycle
    task automatic pulse(input logic w);
        @(posedge clk_i);
        sleep <= !w;
        wake  <= w;
        @(posedge clk_i);
        sleep <= 1'b0;
        wake  <= 1'b0;
        @(negedge clk_i);
    endtask : pulse

    task automatic finish_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        check("config", 32'(cfg), 32'h18);
        for (int i = 0; i < 5; i++) begin
            rd(12'(4 * i), rv[i]);
            wr(12'(4 * i), (i == 1) ? 32'hffff_fffe : '1);
            rd(12'(4 * i), mk[i]);
            wr(12'(4 * i), rv[i]);
        end
        apb(1'b0, 12'h020, '0);
        check("error", 32'(err), 32'h1);
        check("data", q, 32'h0);
        // Divider and clock output counts over 128 high ticks
        for (int j = 0; j < 15; j++) begin
            wr(CGW_OFS_SYS, mv[j]);
            g = 0;
            p = 0;
            t = 0;
            f = 0;
            pv = pin;
            for (int i = 0; i < 132; i++) begin
                @(posedge clk_i);
                hi <= (i < 128);
                lo <= (i < 128) && (i % 4 == 0);
                @(negedge clk_i);
                g += int'(gear);
                p += int'(presc);
                f += int'(periph);
                t += int'(pin != pv);
                pv = pin;
            end
            n = (ms[j] == 0) ? g : (ms[j] == 1) ? p : t;
            check("clock count", n, me[j]);
            if (j == 5) check("periph count", f, 16);
        end
        // Warm-up length for codes 001 to 111 from the high-speed source, then code 001 from the low-speed one
        for (int c = 1; c < 8; c++) begin
            n = 1 << (EXP1 - 1 + c);
            wr(CGW_OFS_OSC, 32'h301 | 32'(c << 4));
            @(negedge clk_i);
            check("busy", busy, 1'b1);
            tk(1'b1, 1'b0, n - 1);
            rd(CGW_OFS_OSC, 32'h302 | 32'(c << 4));
            tk(1'b1, 1'b0, 1);
            repeat (2) @(negedge clk_i);
            check("busy", busy, 1'b0);
        end
        wr(CGW_OFS_OSC, 32'h319);
        tk(1'b1, 1'b0, 8);
        check("busy", busy, 1'b1);
        tk(1'b0, 1'b1, 4);
        repeat (2) @(negedge clk_i);
        check("busy", busy, 1'b0);
        // Start bit, immediate code and the interrupt path
        wr(CGW_OFS_IRQ_CLR, 32'h3);
        wr(CGW_OFS_IRQ_EN, 32'h1);
        wr(CGW_OFS_OSC, 32'h310);
        rd(CGW_OFS_IRQ_STAT, 32'h0);
        wr(CGW_OFS_OSC, 32'h301);
        repeat (2) @(negedge clk_i);
        check("busy", busy, 1'b0);
        check("irq", irq, 1'b1);
        wr(CGW_OFS_IRQ_EN, 32'h2);
        @(negedge clk_i);
        check("irq", irq, 1'b0);
        rd(CGW_OFS_IRQ_STAT, 32'h1);
        wr(CGW_OFS_IRQ_EN, 32'h3);
        wr(CGW_OFS_IRQ_CLR, 32'h1);
        @(negedge clk_i);
        check("irq", irq, 1'b0);
        // Low-power codes, reserved code last
        for (int m = 1; m < 5; m++) begin
            wr(CGW_OFS_LOW_POWER_SELECT, 32'h10100 | 32'(m % 4));
            pulse(1'b0);
            check("mode", 32'(pm), 32'(pe[m % 4]));
            check("stop pins", stopact, m == 1);
            pulse(1'b1);
            check("mode", 32'(pm), 32'(CGW_PM_NORMAL));
        end
        check("irq", irq, 1'b1);
        wr(CGW_OFS_OSC, 32'h314);
        @(negedge clk_i);
        check("config", 32'(cfg), 32'h1c);
        wr(CGW_OFS_PLL, 32'h1);
        wr(CGW_OFS_CKSEL, 32'h2);
        @(negedge clk_i);
        check("config", 32'(cfg), 32'h1f);
        wr(CGW_OFS_OSC, 32'h310);
        @(negedge clk_i);
        check("config", 32'(cfg), 32'h1b);
        finish_test();
    end
endmodule : testbench
